// *** host_command_ack_generator.v ***
// acknowledge and error-response generator for the host command parser
//
// Contract
// - one report code for confirm, success, error
// - single successful reply needs no acknowledge
// - failure or series ends with acknowledge
// - last payload byte is parser status
// - status 1 on framing error, 128 limit
// - status 2 checksum, 3 unknown, 4 length
// - status 5 bad value, 6 contradiction unless override
// - status 7 table full, 8 no data
// - three layouts: non-indexed, indexed, system
// - acknowledge sent before protocol switch
// - non-indexed payload code, subcode, status
// - indexed payload four bytes, length enforced
// - test interval controls are set-only
// - test data from subcode 2 and diagnostics output-only
// - diagnostic toggle query and set allowed
// - initialization inputs query and set allowed
// - channel short status indexed, query only
// - fix and time summaries query only
// - query-all gives one acknowledge with 0xff
// - indexed byte 2 index, byte 3 status
// - system acknowledge subcode 3, status 9 fail
//
// one command is described per cmd_valid pulse; output is a byte stream
// with ack_last on the final byte, first byte the report code.
`include "ack_gen_regs.vh"
`default_nettype none
module host_command_ack_generator (
    input  wire        clk_sys,
    input  wire        nrst,
    input  wire        cmd_valid,
    output reg         cmd_ready,
    input  wire [1:0]  cmd_class,
    input  wire [7:0]  cmd_code,
    input  wire [7:0]  cmd_subcode,
    input  wire [7:0]  cmd_index,
    input  wire [2:0]  cmd_len,
    input  wire [7:0]  stream_len,
    input  wire        frame_err,
    input  wire        csum_err,
    input  wire        value_err,
    input  wire        contradicts,
    input  wire        host_override,
    input  wire        table_full,
    input  wire        no_data,
    input  wire        exec_fail,
    input  wire        reply_count_multi,
    input  wire        proto_change,
    output reg         proto_switch,
    output reg  [7:0]  ack_data,
    output reg         ack_valid,
    output reg         ack_last,
    input  wire        ack_ready,
    output reg  [7:0]  last_status
);
    localparam S_IDLE = 2'h0;
    localparam S_SEND = 2'h1;
    localparam S_DONE = 2'h2;

    reg  [1:0]  state_q;
    reg  [1:0]  state_d;
    reg  [7:0]  b_q [0:5];
    reg  [2:0]  n_q;
    reg  [2:0]  pos_q;
    reg         chg_q;
    reg  [7:0]  status;
    reg  [7:0]  sub_out;
    reg         indexed;
    reg         can_q;
    reg         can_s;
    reg         known;
    reg         need_ack;
    reg  [2:0]  want_len;
    wire [8:0]  buf_in;
    wire        buf_in_ready;
    wire [8:0]  buf_out;
    wire        buf_out_valid;
    wire        push;

    // permission table for report codes handled by this parser
    always @* begin
        indexed = 1'b0;
        can_q   = 1'b1;
        can_s   = 1'b1;
        known   = 1'b1;
        if (cmd_class == `CLS_SYS) begin
            known = 1'b1;
        end else if (cmd_code == `CD_INIT) begin
            can_q = 1'b1;
            can_s = 1'b1;
        end else if (cmd_code == `CD_TESTCTL) begin
            known = (cmd_subcode == 8'h02) || (cmd_subcode == 8'h04) ||
                    (cmd_subcode == 8'h06);
            can_q = 1'b0;
        end else if (cmd_code == `CD_FIX || cmd_code == `CD_TIME) begin
            can_s = 1'b0;
        end else if (cmd_code == `CD_CHSTAT) begin
            indexed = 1'b1;
            can_s   = 1'b0;
        end else if (cmd_code == `CD_TESTDATA &&
                     cmd_subcode >= 8'h02) begin
            can_q = 1'b0;
            can_s = 1'b0;
        end else if (cmd_code == `CD_DIAG) begin
            if (cmd_subcode == `SUB_DIAG_TOGGLE) begin
                can_q = 1'b1;
                can_s = 1'b1;
            end else begin
                can_q = 1'b0;
                can_s = 1'b0;
                indexed = (cmd_subcode == 8'h01);
            end
        end else if (cmd_code[7]) begin
            known = 1'b0;
        end
        if (cmd_class == `CLS_SYS) begin
            want_len = `LEN_SYS;
        end else if (indexed) begin
            want_len = `LEN_IDX;
        end else begin
            want_len = `LEN_NONIDX;
        end
    end

    // status priority follows the order of the parse stages
    always @* begin
        if (frame_err || stream_len > `MAX_STREAM) begin
            status = `ST_PREPARSE;
        end else if (csum_err) begin
            status = `ST_CHECKSUM;
        end else if (!known ||
                     (cmd_class == `CLS_QUERY && !can_q) ||
                     (cmd_class == `CLS_SET && !can_s)) begin
            status = `ST_UNKNOWN;
        end else if (cmd_len != want_len) begin
            status = `ST_LENGTH;
        end else if (cmd_class != `CLS_SYS && value_err) begin
            status = `ST_VALUE;
        end else if (cmd_class != `CLS_SYS && contradicts &&
                     !host_override) begin
            status = `ST_CONTRA;
        end else if (cmd_class != `CLS_SYS && table_full) begin
            status = `ST_FULL;
        end else if (cmd_class != `CLS_SYS && no_data) begin
            status = `ST_NODATA;
        end else if (cmd_class == `CLS_SYS && exec_fail) begin
            status = `ST_EXECFAIL;
        end else begin
            status = `ST_OK;
        end
        case (cmd_class)
            `CLS_SET:   sub_out = `ACK_SUB_SET;
            `CLS_QUERY: sub_out = `ACK_SUB_QUERY;
            `CLS_AUTO:  sub_out = `ACK_SUB_AUTO;
            default:    sub_out = `ACK_SUB_SYS;
        endcase
        // a lone good reply stands as its own acknowledge
        need_ack = (cmd_class == `CLS_SET) || (cmd_class == `CLS_SYS) ||
                   (status != `ST_OK) || reply_count_multi ||
                   (cmd_subcode == `ACK_ALL) ||
                   (indexed && cmd_index == `ACK_ALL);
    end

    always @* begin
        state_d = state_q;
        case (state_q)
            S_IDLE: begin
                if (cmd_valid && need_ack) begin
                    state_d = S_SEND;
                end
            end
            S_SEND: begin
                if (push && pos_q == n_q - 3'h1) begin
                    state_d = S_DONE;
                end
            end
            default: begin
                state_d = S_IDLE;
            end
        endcase
    end

    assign push   = (state_q == S_SEND) && buf_in_ready;
    assign buf_in = {pos_q == n_q - 3'h1, b_q[pos_q]};

    always @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            state_q      <= S_IDLE;
            n_q          <= 3'h0;
            pos_q        <= 3'h0;
            chg_q        <= 1'b0;
            cmd_ready    <= 1'b0;
            proto_switch <= 1'b0;
            last_status  <= `ST_OK;
            b_q[0] <= 8'h00;
            b_q[1] <= 8'h00;
            b_q[2] <= 8'h00;
            b_q[3] <= 8'h00;
            b_q[4] <= 8'h00;
            b_q[5] <= 8'h00;
        end else begin
            state_q      <= state_d;
            proto_switch <= 1'b0;
            // one command at a time keeps acknowledges in order
            cmd_ready    <= (state_d == S_IDLE) && !cmd_valid;
            if (state_q == S_IDLE && cmd_valid) begin
                last_status <= status;
                chg_q       <= proto_change && (status == `ST_OK);
                pos_q       <= 3'h0;
                b_q[0] <= `ACK_CODE;
                b_q[1] <= sub_out;
                b_q[2] <= cmd_code;
                if (cmd_class == `CLS_SYS) begin
                    b_q[3] <= status;
                    n_q    <= 3'h4;
                end else if (indexed) begin
                    b_q[3] <= cmd_subcode;
                    b_q[4] <= cmd_index;
                    b_q[5] <= status;
                    n_q    <= 3'h6;
                end else begin
                    b_q[3] <= cmd_subcode;
                    b_q[4] <= status;
                    n_q    <= 3'h5;
                end
                if (!need_ack && proto_change && status == `ST_OK) begin
                    proto_switch <= 1'b1;
                end
            end else if (push) begin
                pos_q <= pos_q + 3'h1;
            end
            // switch only after the last byte left in the old settings
            // a new command taken on the same edge keeps its own flag
            if (ack_valid && ack_ready && ack_last && chg_q) begin
                proto_switch <= 1'b1;
                chg_q        <= (state_q == S_IDLE) && cmd_valid &&
                                proto_change && (status == `ST_OK);
            end
        end
    end

    ack_buf2 u_buf (
        .clk_sys   (clk_sys),
        .nrst      (nrst),
        .in_data   (buf_in),
        .in_valid  (state_q == S_SEND),
        .in_ready  (buf_in_ready),
        .out_data  (buf_out),
        .out_valid (buf_out_valid),
        .out_ready (ack_ready || !ack_valid)
    );

    always @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            ack_data  <= 8'h00;
            ack_valid <= 1'b0;
            ack_last  <= 1'b0;
        end else if (ack_ready || !ack_valid) begin
            ack_data  <= buf_out[7:0];
            ack_last  <= buf_out[8] && buf_out_valid;
            ack_valid <= buf_out_valid;
        end
    end
endmodule // host_command_ack_generator
`default_nettype wire

// *** ack_gen_regs.vh ***
// constants for the command acknowledge generator
`ifndef ACK_GEN_REGS_VH
`define ACK_GEN_REGS_VH
`define ACK_CODE        8'h10
`define ACK_SUB_SET     8'h01
`define ACK_SUB_QUERY   8'h02
`define ACK_SUB_SYS     8'h03
`define ACK_SUB_AUTO    8'h04
`define ACK_ALL         8'hff
`define ST_OK           8'h00
`define ST_PREPARSE     8'h01
`define ST_CHECKSUM     8'h02
`define ST_UNKNOWN      8'h03
`define ST_LENGTH       8'h04
`define ST_VALUE        8'h05
`define ST_CONTRA       8'h06
`define ST_FULL         8'h07
`define ST_NODATA       8'h08
`define ST_EXECFAIL     8'h09
`define MAX_STREAM      8'h80
`define CLS_SET         2'h0
`define CLS_QUERY       2'h1
`define CLS_AUTO        2'h2
`define CLS_SYS         2'h3
`define CD_INIT         8'h29
`define CD_TESTCTL      8'h2f
`define CD_FIX          8'h31
`define CD_TIME         8'h32
`define CD_CHSTAT       8'h33
`define CD_TESTDATA     8'h3f
`define CD_DIAG         8'h70
`define SUB_DIAG_TOGGLE 8'h7f
`define LEN_NONIDX      3'h3
`define LEN_IDX         3'h4
`define LEN_SYS         3'h2
`endif

// *** ack_buf2.v ***
// two-entry skid buffer for acknowledge bytes
`default_nettype none
module ack_buf2 (
    input  wire        clk_sys,
    input  wire        nrst,
    input  wire [8:0]  in_data,
    input  wire        in_valid,
    output wire        in_ready,
    output reg  [8:0]  out_data,
    output reg         out_valid,
    input  wire        out_ready
);
    reg [8:0] skid_q;
    reg       skid_full_q;

    // ready depends only on the skid slot, so no combinational path back
    assign in_ready = ~skid_full_q;

    always @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            out_data    <= 9'h000;
            out_valid   <= 1'b0;
            skid_q      <= 9'h000;
            skid_full_q <= 1'b0;
        end else begin
            if (out_ready || !out_valid) begin
                if (skid_full_q) begin
                    out_data    <= skid_q;
                    out_valid   <= 1'b1;
                    skid_full_q <= 1'b0;
                end else begin
                    out_data  <= in_data;
                    out_valid <= in_valid;
                end
            end else if (in_valid && !skid_full_q) begin
                skid_q      <= in_data;
                skid_full_q <= 1'b1;
            end
        end
    end
endmodule // ack_buf2
`default_nettype wire

// *** host_ack_sink.sv ***
// host model: takes acknowledge bytes, optionally stalling
`default_nettype none
module host_ack_sink (
    input  wire logic       clk_sys,
    input  wire logic       nrst,
    input  wire logic [7:0] ack_data,
    input  wire logic       ack_valid,
    input  wire logic       ack_last,
    input  wire logic       slow,
    output var  logic       ack_ready
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [7:0] got[$];
    logic [1:0] n_q = 2'h0;
    int         frames = 0;
    initial ack_ready = 1'b0;
    // slow host takes one cycle in four so both buffer entries fill up
    always @(negedge clk_sys) begin
        n_q <= n_q + 2'h1;
        ack_ready <= nrst && (!slow || n_q == 2'h3);
    end
    always @(posedge clk_sys) begin
        if (ack_valid && ack_ready) begin
            got.push_back(ack_data);
            if (ack_last) frames++;
        end
    end
endmodule // host_ack_sink
`default_nettype wire

// *** ack_gen_sva.sv ***
// port assertions for the acknowledge generator
`default_nettype none
module ack_gen_sva (
    input wire logic       clk_sys,
    input wire logic       nrst,
    input wire logic       cmd_valid,
    input wire logic       cmd_ready,
    input wire logic       csum_err,
    input wire logic       proto_change,
    input wire logic       proto_switch,
    input wire logic [7:0] ack_data,
    input wire logic       ack_valid,
    input wire logic       ack_last,
    input wire logic       ack_ready
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!nrst);
    logic mid_q;
    wire  take = cmd_valid && cmd_ready;
    wire  push = ack_valid && ack_ready;
    // marks a frame in progress so its first byte can be told apart
    always @(posedge clk_sys or negedge nrst) begin
        if (!nrst) mid_q <= 1'b0;
        else if (push) mid_q <= !ack_last;
    end
    a_hold_stable: assert property (ack_valid && !ack_ready |=>
        ack_valid && $stable(ack_data) && $stable(ack_last))
        else $error("ack byte changed while stalled");
    a_first_code: assert property (ack_valid && !mid_q |->
        ack_data == 8'h10) else $error("frame does not start with code");
    a_err_acks: assert property (take && csum_err |->
        ##[3:12] ack_valid) else $error("failed command not answered");
    a_busy_take: assert property (take |=> !cmd_ready)
        else $error("ready stayed high after command");
    a_ack_idle: assert property (take && csum_err |=>
        !cmd_ready [*3]) else $error("ready while answer pending");
    a_switch_pulse: assert property (proto_switch |=> !proto_switch)
        else $error("switch pulse too long");
    a_switch_quiet: assert property (proto_switch |-> !ack_valid)
        else $error("switch before answer sent");
    a_err_noswitch: assert property (take && csum_err && proto_change
        |=> !proto_switch [*8]) else $error("rejected command switched");
    c_frame_end: cover property (push && ack_last);
    c_switch: cover property (proto_switch);
    c_stall: cover property (ack_valid && !ack_ready);
endmodule // ack_gen_sva
bind host_command_ack_generator ack_gen_sva sva_u (.clk_sys, .nrst,
    .cmd_valid, .cmd_ready, .csum_err, .proto_change, .proto_switch,
    .ack_data, .ack_valid, .ack_last, .ack_ready);
`default_nettype wire

// *** testbench.sv ***
// self-checking bench for the acknowledge generator
`default_nettype none
module testbench;
    timeunit 1ns;
    timeprecision 1ns;
    typedef struct packed {
        logic [1:0] c;
        logic [7:0] code, sub, idx;
        logic [2:0] len;
        logic [7:0] sl, err;
        logic       m;
        logic [7:0] st;
        logic       ack;
    } row_t;
    logic clk_sys = 0, nrst = 0, cmd_valid = 0, cmd_ready, proto_switch;
    logic [1:0] cmd_class = 2'h0;
    logic [7:0] cmd_code = 8'h00, cmd_subcode = 8'h00, cmd_index = 8'h00;
    logic [2:0] cmd_len = 3'h0;
    logic [7:0] stream_len = 8'h00, ack_data, last_status;
    logic frame_err = 0, csum_err = 0, value_err = 0, contradicts = 0;
    logic host_override = 0, table_full = 0, no_data = 0, exec_fail = 0;
    logic reply_count_multi = 0, proto_change = 0;
    logic ack_valid, ack_last, ack_ready, slow = 0;
    int   fail_count = 0, cmp_count = 0, cyc = 0, sw_cnt = 0;
    row_t rows[] = '{
        '{0,8'h29,8'h01,0,3,8'h80,8'h00,0,8'h00,1},
        '{1,8'h29,8'h01,0,3,8'h10,8'h00,0,8'h00,0},
        '{1,8'h29,8'hff,0,3,8'h10,8'h00,1,8'h00,1},
        '{2,8'h29,8'h01,0,3,8'h10,8'h80,0,8'h01,1},
        '{0,8'h29,8'h01,0,3,8'h81,8'h00,0,8'h01,1},
        '{0,8'h29,8'h01,0,3,8'h10,8'h40,0,8'h02,1},
        '{0,8'h29,8'h01,0,4,8'h10,8'h00,0,8'h04,1},
        '{0,8'h29,8'h01,0,3,8'h10,8'h20,0,8'h05,1},
        '{0,8'h29,8'h01,0,3,8'h10,8'h10,0,8'h06,1},
        '{0,8'h29,8'h01,0,3,8'h10,8'h18,0,8'h00,1},
        '{0,8'h29,8'h01,0,3,8'h10,8'h04,0,8'h07,1},
        '{0,8'h29,8'h01,0,3,8'h10,8'h02,0,8'h08,1},
        '{1,8'h2f,8'h02,0,3,8'h10,8'h00,0,8'h03,1},
        '{0,8'h2f,8'h06,0,3,8'h10,8'h00,0,8'h00,1},
        '{0,8'h31,8'h01,0,3,8'h10,8'h00,0,8'h03,1},
        '{0,8'h3f,8'h02,0,3,8'h10,8'h00,0,8'h03,1},
        '{1,8'h70,8'h02,0,3,8'h10,8'h00,0,8'h03,1},
        '{0,8'h70,8'h7f,0,3,8'h10,8'h00,0,8'h00,1},
        '{0,8'h33,8'h01,5,4,8'h10,8'h00,0,8'h03,1},
        '{1,8'h33,8'h01,8'hff,4,8'h10,8'h00,1,8'h00,1},
        '{3,8'h03,8'h01,0,2,8'h10,8'h01,0,8'h09,1},
        '{3,8'h03,8'h02,0,2,8'h10,8'h00,0,8'h00,1}};
    always #50 clk_sys = ~clk_sys;
    host_command_ack_generator dut_u (.clk_sys, .nrst, .cmd_valid,
        .cmd_ready, .cmd_class, .cmd_code, .cmd_subcode, .cmd_index,
        .cmd_len, .stream_len, .frame_err, .csum_err, .value_err,
        .contradicts, .host_override, .table_full, .no_data, .exec_fail,
        .reply_count_multi, .proto_change, .proto_switch, .ack_data,
        .ack_valid, .ack_last, .ack_ready, .last_status);
    host_ack_sink mdl_u (.clk_sys, .nrst, .ack_data, .ack_valid,
        .ack_last, .slow, .ack_ready);
    task automatic final_report();
        $display("compares %0d mismatches %0d", cmp_count, fail_count);
        if (fail_count == 0 && cmp_count > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask
    always @(posedge clk_sys) begin
        cyc++;
        if (proto_switch === 1'b1) sw_cnt++;
        if (cyc == 5000) begin
            fail_count++;
            final_report();
        end
    end
    task automatic check(string nm, logic [7:0] seen, logic [7:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            fail_count++;
            $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic run(row_t r);
        logic [7:0] e[$];
        int n;
        mdl_u.got.delete();
        n = mdl_u.frames;
        while (cmd_ready !== 1'b1) @(negedge clk_sys);
        {cmd_class, cmd_code, cmd_subcode, cmd_index} = {r.c, r.code,
            r.sub, r.idx};
        {cmd_len, stream_len, reply_count_multi} = {r.len, r.sl, r.m};
        {frame_err, csum_err, value_err, contradicts, host_override,
            table_full, no_data, exec_fail} = r.err;
        cmd_valid = 1'b1;
        @(negedge clk_sys);
        cmd_valid = 1'b0;
        e = '{8'h10, r.c == 2'h3 ? 8'h03 : 8'h01 << r.c, r.code};
        if (r.c != 2'h3) e.push_back(r.sub);
        if (r.c != 2'h3 && (r.code == 8'h33 || r.code == 8'h70
            && r.sub == 8'h01)) e.push_back(r.idx);
        e.push_back(r.st);
        if (!r.ack) e = {};
        for (int k = 0; k < 60 && mdl_u.frames == n; k++)
            @(negedge clk_sys);
        check("count", 8'(mdl_u.got.size()), 8'(e.size()));
        foreach (e[i]) check("byte", i < mdl_u.got.size() ?
            mdl_u.got[i] : 8'hxx, e[i]);
        check("status", last_status, r.st);
    endtask
    initial begin
        repeat (20) @(negedge clk_sys);
        nrst = 1'b1;
        foreach (rows[i]) begin
            slow = i[0];
            run(rows[i]);
            $display("row %0d done", i);
        end
        proto_change = 1'b1;
        sw_cnt = 0;
        run('{0,8'h29,8'h01,0,3,8'h10,8'h00,0,8'h00,1});
        // the switch pulse follows the last handshake by one edge
        repeat (2) @(negedge clk_sys);
        check("switch", 8'(sw_cnt), 8'h01);
        sw_cnt = 0;
        run('{0,8'h29,8'h01,0,3,8'h10,8'h40,0,8'h02,1});
        check("error switch", 8'(sw_cnt), 8'h00);
        proto_change = 1'b0;
        $display("switch test done");
        nrst = 1'b0;
        @(negedge clk_sys);
        check("ready in reset", {7'h0, cmd_ready}, 8'h00);
        check("valid in reset", {7'h0, ack_valid}, 8'h00);
        nrst = 1'b1;
        repeat (2) @(negedge clk_sys);
        check("ready after", {7'h0, cmd_ready}, 8'h01);
        $display("reset test done");
        final_report();
    end
endmodule // testbench
`default_nettype wire
